// File: flash_cfg_pkg.sv
// constants and types for the flash timing and security front end
package flash_cfg_pkg;
    // register addresses on the cpu/debug byte bus
    localparam logic [15:0] ADDR_DIVIDER    = 16'h1820;
    localparam logic [15:0] ADDR_OPTION     = 16'h1821;
    localparam logic [15:0] ADDR_PROTECTION = 16'h1824;
    localparam logic [15:0] ADDR_STATUS     = 16'h1825;
    localparam logic [15:0] ADDR_KEY_BASE   = 16'hffb0;
    localparam logic [15:0] ADDR_NV_PROT    = 16'hffbd;
    localparam logic [15:0] ADDR_NV_OPT     = 16'hffbf;
    localparam int          KEY_BYTES       = 8;
    // divider register fields
    localparam int DIV_LOADED_BIT   = 7;
    localparam int DIV_PRESCALE_BIT = 6;
    localparam int PRESCALE_RATIO   = 8;
    // option register fields
    localparam int          OPT_BACKDOOR_KEY_ENABLE_BIT  = 7;
    localparam int          OPT_REDIR_BIT  = 6;
    localparam logic [1:0]  SEC_UNSECURED  = 2'h2;
    // status register fields
    localparam int STAT_DONE_BIT  = 6;
    localparam int STAT_ERR_BIT   = 4;
    localparam int STAT_BLANK_BIT = 2;
    // reset values
    localparam logic [7:0] DIVIDER_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    // timing clock window, software picks the divider for it
    localparam int FLASH_TIMING_CLOCK_MIN_KHZ = 150;
    localparam int FLASH_TIMING_CLOCK_MAX_KHZ = 200;
    localparam int BUS_CLK_KHZ  = 40000;
    localparam int DIVISOR_MIN  = (BUS_CLK_KHZ + FLASH_TIMING_CLOCK_MAX_KHZ - 1) / FLASH_TIMING_CLOCK_MAX_KHZ;
    localparam int DIVISOR_MAX  = BUS_CLK_KHZ / FLASH_TIMING_CLOCK_MIN_KHZ;
    // command durations in timing-clock periods
    localparam logic [14:0] BYTE_PROG_TICKS  = 15'h0009;
    localparam logic [14:0] BURST_PROG_TICKS = 15'h0004;
    localparam int          PAGE_ERASE_TICKS = 4000;
    localparam int          MASS_ERASE_TICKS = 20000;
    // flash array geometry
    localparam int PAGE_BYTES = 512;
    localparam int PAGE_COUNT = 124;
    localparam int PAGE_SHIFT = 9;
    // command kinds handled by the timer
    typedef enum logic [1:0] {
        CMD_BYTE  = 2'b00,
        CMD_BURST = 2'b01,
        CMD_PAGE  = 2'b10,
        CMD_MASS  = 2'b11
    } cmd_kind_t;
    typedef enum logic [0:0] {
        TMR_IDLE = 1'b0,
        TMR_RUN  = 1'b1
    } tmr_state_t;
endpackage

// File: flash_timing_if.sv
// link between the config front end and the command timer
`timescale 1ns/1ps
`default_nettype none
interface flash_timing_if;
    import flash_cfg_pkg::*;
    logic       divLoaded;
    logic       prescale8;
    logic [5:0] divValue;
    logic       start;
    cmd_kind_t  kind;
    logic       busy;
    logic       done;
    logic       tick;
    modport ctrl (output divLoaded, prescale8, divValue, start, kind,
                  input busy, done, tick);
    modport timer (input divLoaded, prescale8, divValue, start, kind,
                   output busy, done, tick);
endinterface
`default_nettype wire

// File: flash_timer.sv
// timing clock divider and command duration counter
`timescale 1ns/1ps
`default_nettype none
module flash_timer #(
    parameter int PAGE_TICKS = flash_cfg_pkg::PAGE_ERASE_TICKS,
    parameter int MASS_TICKS = flash_cfg_pkg::MASS_ERASE_TICKS
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    flash_timing_if.timer    tif
);
    import flash_cfg_pkg::*;

    tmr_state_t  state,     next_state;
    logic [2:0]  preCount,  next_preCount;
    logic [5:0]  divCount,  next_divCount;
    logic [14:0] remaining, next_remaining;
    logic        done,      next_done;
    logic        preWrap;
    logic        tick;

    // duration of each command kind in timing-clock periods
    function automatic logic [14:0] ticksFor(input cmd_kind_t k);
        case (k)
            CMD_BYTE:  ticksFor = BYTE_PROG_TICKS;
            CMD_BURST: ticksFor = BURST_PROG_TICKS;
            CMD_PAGE:  ticksFor = 15'(PAGE_TICKS);
            default:   ticksFor = 15'(MASS_TICKS);
        endcase
    endfunction

    // timing clock is bus clock over (div+1), and over 8 more with prescale
    assign preWrap = !tif.prescale8 || (preCount == 3'(PRESCALE_RATIO - 1));
    assign tick    = tif.divLoaded && preWrap && (divCount == tif.divValue);
    assign tif.tick = tick;
    assign tif.busy = (state == TMR_RUN);
    assign tif.done = done;

    // next-state for divider chain and duration counter
    always_comb begin
        next_preCount  = preCount;
        next_divCount  = divCount;
        next_state     = state;
        next_remaining = remaining;
        next_done      = 1'b0;
        if (tif.divLoaded) begin
            next_preCount = preWrap ? 3'h0 : preCount + 3'h1;
            if (preWrap) begin
                next_divCount = tick ? 6'h00 : divCount + 6'h01;
            end
        end
        case (state)
            TMR_IDLE: begin
                if (tif.start && tif.divLoaded) begin
                    next_remaining = ticksFor(tif.kind);
                    next_state     = TMR_RUN;
                end
            end
            TMR_RUN: begin
                if (tick) begin
                    next_remaining = remaining - 15'h0001;
                    if (remaining == 15'h0001) begin
                        next_state = TMR_IDLE;
                        next_done  = 1'b1;
                    end
                end
            end
            default: next_state = TMR_IDLE;
        endcase
    end

    // register stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= TMR_IDLE;
            preCount  <= 3'h0;
            divCount  <= 6'h00;
            remaining <= 15'h0000;
            done      <= 1'b0;
        end else begin
            state     <= next_state;
            preCount  <= next_preCount;
            divCount  <= next_divCount;
            remaining <= next_remaining;
            done      <= next_done;
        end
    end

    AST_LOAD_DURATION: assert property (@(posedge clk) disable iff (sys_rst)
        (state == TMR_IDLE && tif.start && tif.divLoaded)
            |=> (state == TMR_RUN) && (remaining == ticksFor($past(tif.kind))))
        else $error("duration not loaded for command kind");
    AST_COUNT_ON_TICK: assert property (@(posedge clk) disable iff (sys_rst)
        (state == TMR_RUN && !tick) |=> $stable(remaining) && (state == TMR_RUN))
        else $error("duration moved without a timing tick");
    AST_TICK_SPACING: assert property (@(posedge clk) disable iff (sys_rst)
        (tick && tif.prescale8 && $stable(tif.divValue)) |=> !tick)
        else $error("prescaled timing tick repeated too soon");
endmodule // flash_timer
`default_nettype wire

// File: flash_timing_security_config.sv
// flash clock divider, reset option copy, security and backdoor key gating
`timescale 1ns/1ps
`default_nettype none
module flash_timing_security_config #(
    parameter int PAGE_TICKS = flash_cfg_pkg::PAGE_ERASE_TICKS,
    parameter int MASS_TICKS = flash_cfg_pkg::MASS_ERASE_TICKS
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic [15:0]              busAddr,
    input  wire logic [7:0]               busWdata,
    input  wire logic                     busWrite,
    input  wire logic                     busRead,
    input  wire logic                     busFromDebug,
    input  wire logic                     busFromSecure,
    output logic [7:0]                    busRdata,
    input  wire logic [7:0]               nvProtByte,
    input  wire logic [7:0]               nvOptByte,
    input  wire logic [63:0]              backdoorKey,
    input  wire logic                     cmdStart,
    input  wire flash_cfg_pkg::cmd_kind_t cmdKind,
    input  wire logic [15:0]              cmdAddr,
    input  wire logic                     blankPass,
    input  wire logic                     accessErrorEvent,
    input  wire logic                     ramReq,
    input  wire logic                     ramFromDebug,
    input  wire logic                     ramFromSecure,
    output logic                          ramGrant,
    output logic                          cmdBusy,
    output logic                          cmdDone,
    output logic                          timingTick,
    output logic                          secured,
    output logic [7:0]                    protectionReg,
    output logic [6:0]                    erasePage
);
    import flash_cfg_pkg::*;

    flash_timing_if tif ();

    logic [7:0] dividerReg,  next_dividerReg;
    logic [7:0] optionReg,   next_optionReg;
    logic [7:0] next_protectionReg;
    logic       errFlag,     next_errFlag;
    logic       blankFlag,   next_blankFlag;
    logic       massErased,  next_massErased;
    logic       unlocked,    next_unlocked;
    logic [7:0] keyMask,     next_keyMask;
    logic [7:0] keyStore [KEY_BYTES];
    logic [7:0] next_keyStore [KEY_BYTES];
    logic [6:0] next_erasePage;
    logic [7:0] next_busRdata;
    logic       divWriteOk;
    logic       cmdReject;
    logic       keyWrite;
    logic [63:0] keyWord;
    logic [6:0] cmdPage;

    // register select by address
    function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    // page number of a flash address
    function automatic logic [6:0] pageOf(input logic [15:0] a);
        pageOf = a[15:PAGE_SHIFT];
    endfunction

    flash_timer #(
        .PAGE_TICKS (PAGE_TICKS),
        .MASS_TICKS (MASS_TICKS)
    ) u_timer (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tif     (tif.timer)
    );

    // divider fields and command launch toward the timer
    assign tif.divLoaded = dividerReg[DIV_LOADED_BIT];
    assign tif.prescale8 = dividerReg[DIV_PRESCALE_BIT];
    assign tif.divValue  = dividerReg[5:0];
    assign tif.kind      = cmdKind;
    assign cmdPage       = pageOf(cmdAddr);
    assign cmdReject     = !dividerReg[DIV_LOADED_BIT] || tif.busy || errFlag
                           || (cmdKind == CMD_PAGE && cmdPage >= 7'(PAGE_COUNT));
    assign tif.start     = cmdStart && !cmdReject;
    assign cmdBusy       = tif.busy;
    assign cmdDone       = tif.done;
    assign timingTick    = tif.tick;

    // write-once divider, blocked by a pending access error
    assign divWriteOk = busWrite && hit(busAddr, ADDR_DIVIDER)
                        && !dividerReg[DIV_LOADED_BIT] && !errFlag;

    // key bytes only from user code in secure memory, key enabled
    assign keyWrite = busWrite && !busFromDebug && busFromSecure
                      && optionReg[OPT_BACKDOOR_KEY_ENABLE_BIT]
                      && (busAddr[15:3] == ADDR_KEY_BASE[15:3]);
    always_comb begin
        for (int i = 0; i < KEY_BYTES; i++) begin
            keyWord[63 - 8*i -: 8] = keyStore[i];
        end
    end

    // security state and ram gate
    assign secured  = (optionReg[1:0] != SEC_UNSECURED) && !unlocked;
    assign ramGrant = ramReq && (!secured || (!ramFromDebug && ramFromSecure));

    // next values of working registers and flags
    always_comb begin
        next_dividerReg    = dividerReg;
        next_optionReg     = optionReg;
        next_protectionReg = protectionReg;
        next_errFlag       = errFlag;
        next_blankFlag     = blankFlag;
        next_massErased    = massErased;
        next_unlocked      = unlocked;
        next_keyMask       = keyMask;
        next_keyStore      = keyStore;
        next_erasePage     = erasePage;
        next_busRdata      = busRdata;
        if (divWriteOk) begin
            next_dividerReg = {1'b1, busWdata[6:0]};
        end
        if (busWrite && hit(busAddr, ADDR_PROTECTION) && busFromDebug) begin
            next_protectionReg = busWdata;
        end
        // clear on write-one, a same-cycle error wins
        if (busWrite && hit(busAddr, ADDR_STATUS) && busWdata[STAT_ERR_BIT]) begin
            next_errFlag = 1'b0;
        end
        if (accessErrorEvent || (cmdStart && cmdReject)) begin
            next_errFlag = 1'b1;
        end
        if (tif.start) begin
            next_blankFlag = 1'b0;
            if (cmdKind == CMD_PAGE) begin
                next_erasePage = cmdPage;
            end
        end
        if (blankPass) begin
            next_blankFlag = 1'b1;
        end
        if (tif.done && cmdKind == CMD_MASS) begin
            next_massErased = 1'b1;
        end
        if (massErased && blankPass) begin
            next_unlocked = 1'b1;
        end
        // collect eight key bytes, compare once all arrived
        if (keyWrite) begin
            next_keyStore[busAddr[2:0]] = busWdata;
            next_keyMask[busAddr[2:0]]  = 1'b1;
        end
        if (keyMask == 8'hff) begin
            next_keyMask = 8'h00;
            if (keyWord == backdoorKey && optionReg[OPT_BACKDOOR_KEY_ENABLE_BIT]) begin
                next_unlocked = 1'b1;
            end
        end
        // registered read data, unmapped addresses read zero
        if (busRead) begin
            if (hit(busAddr, ADDR_DIVIDER)) begin
                next_busRdata = dividerReg;
            end else if (hit(busAddr, ADDR_OPTION)) begin
                next_busRdata = optionReg;
            end else if (hit(busAddr, ADDR_PROTECTION)) begin
                next_busRdata = protectionReg;
            end else if (hit(busAddr, ADDR_STATUS)) begin
                next_busRdata = 8'h00;
                next_busRdata[STAT_DONE_BIT]  = !tif.busy;
                next_busRdata[STAT_ERR_BIT]   = errFlag;
                next_busRdata[STAT_BLANK_BIT] = blankFlag;
            end else if (hit(busAddr, ADDR_NV_PROT)) begin
                next_busRdata = nvProtByte;
            end else if (hit(busAddr, ADDR_NV_OPT)) begin
                next_busRdata = nvOptByte;
            end else begin
                next_busRdata = 8'h00;
            end
        end
    end

    // register stage, reset loads the nonvolatile bytes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dividerReg    <= DIVIDER_RESET;
            optionReg     <= nvOptByte;
            protectionReg <= nvProtByte;
            errFlag       <= STATUS_RESET[STAT_ERR_BIT];
            blankFlag     <= 1'b0;
            massErased    <= 1'b0;
            unlocked      <= 1'b0;
            keyMask       <= 8'h00;
            for (int i = 0; i < KEY_BYTES; i++) begin
                keyStore[i] <= 8'h00;
            end
            erasePage     <= 7'h00;
            busRdata      <= 8'h00;
        end else begin
            dividerReg    <= next_dividerReg;
            optionReg     <= next_optionReg;
            protectionReg <= next_protectionReg;
            errFlag       <= next_errFlag;
            blankFlag     <= next_blankFlag;
            massErased    <= next_massErased;
            unlocked      <= next_unlocked;
            keyMask       <= next_keyMask;
            keyStore      <= next_keyStore;
            erasePage     <= next_erasePage;
            busRdata      <= next_busRdata;
        end
    end

    AST_DIV_ONCE: assert property (@(posedge clk) disable iff (sys_rst)
        dividerReg[DIV_LOADED_BIT] |=> $stable(dividerReg))
        else $error("divider changed after its single write");
    AST_DIV_ERR_BLOCK: assert property (@(posedge clk) disable iff (sys_rst)
        (!dividerReg[DIV_LOADED_BIT] && errFlag) |=> !dividerReg[DIV_LOADED_BIT])
        else $error("divider written while access error set");
    AST_PROT_DEBUG_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
        (busWrite && !busFromDebug) |=> $stable(protectionReg))
        else $error("protection changed by application write");
    AST_RESET_COPY: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> (optionReg == $past(nvOptByte))
                           && (protectionReg == $past(nvProtByte)))
        else $error("working registers not loaded at reset");
    AST_UNLOCK_CAUSE: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(unlocked) |-> $past(optionReg[OPT_BACKDOOR_KEY_ENABLE_BIT]) || $past(massErased))
        else $error("unlock without key enable or mass erase");
    AST_SEC_DECODE: assert property (@(posedge clk) disable iff (sys_rst)
        $past(sys_rst) |-> (secured == ($past(nvOptByte[1:0]) != SEC_UNSECURED)))
        else $error("security state does not follow option field");
    AST_RAM_DENY: assert property (@(posedge clk) disable iff (sys_rst)
        (secured && (ramFromDebug || !ramFromSecure)) |-> !ramGrant)
        else $error("secured ram granted to debug or non-secure code");
    AST_ERR_SET_WINS: assert property (@(posedge clk) disable iff (sys_rst)
        accessErrorEvent |=> errFlag)
        else $error("access error event lost");
    AST_NO_START_UNLOADED: assert property (@(posedge clk) disable iff (sys_rst)
        (cmdStart && !dividerReg[DIV_LOADED_BIT]) |=> !cmdBusy && errFlag)
        else $error("command started before divider written");
endmodule // flash_timing_security_config
`default_nettype wire

// File: nv_array_model.sv
// nonvolatile array stand-in: option, protection and key images plus blank check
`timescale 1ns/1ps
`default_nettype none
module nv_array_model (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic [7:0]               optImage,
    input  wire logic [7:0]               protImage,
    input  wire logic [63:0]              keyImage,
    input  wire logic                     cmdDone,
    input  wire flash_cfg_pkg::cmd_kind_t cmdKind,
    input  wire logic                     blankReq,
    output logic [7:0]                    nvOptByte,
    output logic [7:0]                    nvProtByte,
    output logic [63:0]                   backdoorKey,
    output logic                          blankPass
);
    import flash_cfg_pkg::*;
    logic erased;
    logic next_erased;
    logic next_blankPass;
    // stored bytes as the bench programmed them
    assign nvOptByte   = optImage;
    assign nvProtByte  = protImage;
    assign backdoorKey = keyImage;
    // blank only after a finished mass erase; check answers one cycle later
    always_comb begin
        next_erased    = erased | (cmdDone & (cmdKind == CMD_MASS));
        next_blankPass = blankReq & erased;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            erased    <= 1'b0;
            blankPass <= 1'b0;
        end else begin
            erased    <= next_erased;
            blankPass <= next_blankPass;
        end
    end
endmodule // nv_array_model
`default_nettype wire

// File: flash_timing_security_config_bench.sv
// self-checking bench for the flash timing and security front end
`timescale 1ns/1ps
`default_nettype none
module flash_timing_security_config_bench;
    import flash_cfg_pkg::*;
    localparam int         PT      = 5;
    localparam int         MT      = 8;
    localparam logic [7:0] DIV_VAL = 8'h58; // prescale 8, div 24: 200 cycles per tick
    logic        clk, sys_rst, busWrite, busRead, busFromDebug, busFromSecure;
    logic [15:0] busAddr, cmdAddr;
    logic [7:0]  busWdata, busRdata, nvProtByte, nvOptByte, optImage, protImage;
    logic [63:0] backdoorKey, keyImage;
    logic        cmdStart, blankPass, blankReq, accessErrorEvent, ramReq;
    logic        ramFromDebug, ramFromSecure, ramGrant, cmdBusy, cmdDone, timingTick, secured;
    logic [7:0]  protectionReg;
    logic [6:0]  erasePage;
    cmd_kind_t   cmdKind;
    logic [31:0] seed = 32'h0000_9743;
    int          fails = 0;
    int          comparisons = 0;

    flash_timing_security_config #(.PAGE_TICKS(PT), .MASS_TICKS(MT)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWdata(busWdata),
        .busWrite(busWrite), .busRead(busRead), .busFromDebug(busFromDebug),
        .busFromSecure(busFromSecure), .busRdata(busRdata), .nvProtByte(nvProtByte),
        .nvOptByte(nvOptByte), .backdoorKey(backdoorKey), .cmdStart(cmdStart),
        .cmdKind(cmdKind), .cmdAddr(cmdAddr), .blankPass(blankPass),
        .accessErrorEvent(accessErrorEvent), .ramReq(ramReq), .ramFromDebug(ramFromDebug),
        .ramFromSecure(ramFromSecure), .ramGrant(ramGrant), .cmdBusy(cmdBusy),
        .cmdDone(cmdDone), .timingTick(timingTick), .secured(secured),
        .protectionReg(protectionReg), .erasePage(erasePage));
    nv_array_model u_nv (
        .clk(clk), .sys_rst(sys_rst), .optImage(optImage), .protImage(protImage),
        .keyImage(keyImage), .cmdDone(cmdDone), .cmdKind(cmdKind), .blankReq(blankReq),
        .nvOptByte(nvOptByte), .nvProtByte(nvProtByte), .backdoorKey(backdoorKey),
        .blankPass(blankPass));

    // bus clock, 25 ns
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int ticks_for(input int k);
        case (k)
            0: return 9;
            1: return 4;
            2: return PT;
            default: return MT;
        endcase
    endfunction
    function automatic int tick_cycles(input logic [7:0] v);
        return (int'(v[5:0]) + 1) * (v[6] ? 8 : 1);
    endfunction
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // one write, strobe high for one edge, data scrambled once released
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d, input logic dbg,
                          input logic sec);
        busAddr = a;
        busWdata = d;
        busFromDebug = dbg;
        busFromSecure = sec;
        busWrite = 1'b1;
        step();
        busWrite = 1'b0;
        busWdata = ~d;
        step();
    endtask
    task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
        busAddr = a;
        busRead = 1'b1;
        step();
        busRead = 1'b0;
        d = busRdata;
        step();
    endtask
    task automatic do_reset(input logic [7:0] opt);
        optImage = opt;
        sys_rst = 1'b1;
        repeat (4) step();
        sys_rst = 1'b0;
        step();
    endtask
    task automatic run_cmd(input int k, input logic [15:0] a);
        int ticks = 0;
        int cyc = 0;
        cmdKind = cmd_kind_t'(k);
        cmdAddr = a;
        cmdStart = 1'b1;
        step();
        cmdStart = 1'b0;
        check("cmdBusy", 1, cmdBusy);
        while (cmdDone !== 1'b1 && cyc < 20000) begin
            if (timingTick === 1'b1 && cmdBusy === 1'b1) ticks++;
            cyc++;
            step();
        end
        check("cmdBusy at done", 0, cmdBusy);
        check("tick count", ticks_for(k), ticks);
        check("cmdDone", 1, cmdDone);
        step();
        check("cmdDone one cycle", 0, cmdDone);
    endtask
    task automatic key_entry(input logic [63:0] key, input logic dbg, input logic sec);
        for (int i = 0; i < KEY_BYTES; i++) bus_wr(ADDR_KEY_BASE + 16'(i), key[63-8*i -: 8], dbg, sec);
        step();
    endtask
    task automatic ram_chk(input logic dbg, input logic sec, input logic exp);
        ramReq = 1'b1;
        ramFromDebug = dbg;
        ramFromSecure = sec;
        step();
        check("ramGrant", exp, ramGrant);
    endtask
    // refused launch: no busy, error flag set, then cleared
    task automatic refused_start(input string what);
        logic [7:0] s;
        cmdStart = 1'b1;
        step();
        cmdStart = 1'b0;
        check(what, 0, cmdBusy);
        bus_rd(ADDR_STATUS, s);
        check("error flag", 8'h10, s & 8'h10);
        bus_wr(ADDR_STATUS, 8'h10, 0, 1);
    endtask
    // watchdog cuts a hang short, sized past the longest erase
    initial begin
        #2_000_000;
        fails++;
        print_verdict();
    end
    // main sequence
    initial begin
        int p;
        logic [7:0] d;
        {sys_rst, busWrite, busRead, busFromDebug, busFromSecure, cmdStart} = '0;
        {blankReq, accessErrorEvent, ramReq, ramFromDebug, ramFromSecure} = '0;
        {busAddr, busWdata, cmdAddr} = '0;
        cmdKind = CMD_BYTE;
        optImage = 8'h80;
        protImage = 8'(rnd());
        keyImage = {rnd(), rnd()};
        #1;
        // every security field value
        for (int s = 0; s < 4; s++) begin
            do_reset(8'hc0 | 8'(s));
            bus_rd(ADDR_OPTION, d);
            check("option copy", 8'hc0 | 8'(s), d);
            check("protection copy", protImage, protectionReg);
            check("secured", s != 2, secured);
        end
        $display("test reset copy done");
        do_reset(8'h80);
        // error flag blocks divider; then single write only
        accessErrorEvent = 1'b1;
        step();
        accessErrorEvent = 1'b0;
        bus_wr(ADDR_DIVIDER, DIV_VAL, 0, 1);
        bus_rd(ADDR_DIVIDER, d);
        check("divider blocked", DIVIDER_RESET, d);
        bus_wr(ADDR_STATUS, 8'h10, 0, 1);
        bus_wr(ADDR_DIVIDER, DIV_VAL, 0, 1);
        bus_wr(ADDR_DIVIDER, 8'h01, 0, 1);
        bus_rd(ADDR_DIVIDER, d);
        check("divider once", DIV_VAL | 8'h80, d);
        while (timingTick !== 1'b1) step();
        p = 0;
        do begin
            step();
            p++;
        end while (timingTick !== 1'b1 && p < 2000);
        check("tick period", tick_cycles(DIV_VAL), p);
        $display("test divider done");
        // all kinds, random pages, last page, page past the end
        for (int k = 0; k < 4; k++) begin
            cmdAddr = {7'(rnd() % PAGE_COUNT), 9'(rnd())};
            run_cmd(k, cmdAddr);
            if (k == 2) check("erasePage", cmdAddr[15:9], erasePage);
        end
        run_cmd(2, 16'hf7ff);
        check("last page", 7'd123, erasePage);
        cmdAddr = 16'hf800;
        refused_start("busy on refused");
        $display("test commands done");
        // protection writable only from debug
        d = protImage ^ (8'(rnd()) | 8'h01);
        bus_wr(ADDR_PROTECTION, d, 0, 1);
        check("prot app write", protImage, protectionReg);
        bus_wr(ADDR_PROTECTION, d, 1, 0);
        check("prot debug write", d, protectionReg);
        // key enabled: origin and value of the key matter
        ram_chk(1, 0, 0);
        ram_chk(0, 0, 0);
        ram_chk(0, 1, 1);
        key_entry(keyImage, 1, 0);
        check("debug key", 1, secured);
        key_entry(keyImage ^ 64'h1, 0, 1);
        check("wrong key", 1, secured);
        key_entry(keyImage, 0, 1);
        check("good key", 0, secured);
        ram_chk(1, 0, 1);
        $display("test key done");
        // key disabled: only mass erase plus blank unlocks; reset rearms divider
        do_reset(8'h00);
        bus_rd(ADDR_DIVIDER, d);
        check("divider after reset", DIVIDER_RESET, d);
        refused_start("busy unloaded");
        bus_wr(ADDR_DIVIDER, DIV_VAL, 0, 1);
        bus_rd(ADDR_DIVIDER, d);
        check("divider rearmed", DIV_VAL | 8'h80, d);
        key_entry(keyImage, 0, 1);
        check("key disabled", 1, secured);
        for (int i = 0; i < 2; i++) begin
            if (i == 1) run_cmd(3, 16'h0000);
            blankReq = 1'b1;
            step();
            blankReq = 1'b0;
            repeat (2) step();
            check("blank unlock", i == 0, secured);
            bus_rd(ADDR_STATUS, d);
            check("status blank", (i == 1) ? 8'h44 : 8'h40, d & 8'h44);
        end
        $display("test erase unlock done");
        print_verdict();
    end
endmodule // flash_timing_security_config_bench
`default_nettype wire
